// *** design/cpu_alu_params.svh ***
// Operation
// RULE1: Add two registers, optionally plus carry; update Z C N V H; one cycle.
// RULE2: Word add of a constant to a register pair; Z C N V S; two cycles.
// RULE3: Subtract register or constant; store; update Z C N V H; one cycle.
// RULE4: Subtract with borrow also subtracts carry; Z C N V H; one cycle.
// RULE5: Word subtract of a constant from a pair; Z C N V S; two cycles.
// RULE6: AND with register or constant; only Z N V change; one cycle.
// RULE7: OR with register or constant, XOR of registers; Z N V; one cycle.
// RULE8: Invert gives 0xFF minus value; Z C N V change; one cycle.
// RULE9: Clear bits ANDs with 0xFF minus mask; Z N V; one cycle.
// RULE10: Test ANDs register with itself, value unchanged; Z N V; one cycle.
// RULE11: Indirect jump loads PC from Z pointer; no flags; two cycles.
// RULE12: Indirect call saves return address, PC from Z; three cycles.
// RULE13: Compare skip equal advances PC 2 or 3 when equal, else 1.
// RULE14: Compare constant computes difference unstored; Z N V C H; one cycle.
// RULE15: Skip if selected bit clear advances PC 2 or 3; no flags.
// RULE16: Skip distance and cycles follow the skipped instruction's word count.
// RULE17: Unlisted flags keep values; registers and byte results are 8 bits.
`ifndef CPU_ALU_PARAMS_SVH
`define CPU_ALU_PARAMS_SVH
`define ALU_FLAG_C 0
`define ALU_FLAG_Z 1
`define ALU_FLAG_N 2
`define ALU_FLAG_V 3
`define ALU_FLAG_S 4
`define ALU_FLAG_H 5
`define ALU_FLAGS_RESET 6'h00
`define ALU_CYC_ONE 2'h1
`define ALU_CYC_TWO 2'h2
`define ALU_CYC_THREE 2'h3
`define ALU_ALL_ONES 8'hff
`endif

// *** design/cpu_alu_pkg.sv ***
package cpu_alu_pkg;
  typedef enum logic [4:0] {
    op_add                           = 5'h00,
    op_add_carry                     = 5'h01,
    op_word_add_immediate            = 5'h02,
    op_subtract                      = 5'h03,
    op_subtract_constant             = 5'h04,
    op_subtract_with_borrow          = 5'h05,
    op_subtract_constant_with_borrow = 5'h06,
    op_word_subtract_immediate       = 5'h07,
    op_and                           = 5'h08,
    op_and_constant                  = 5'h09,
    op_or                            = 5'h0a,
    op_or_constant                   = 5'h0b,
    op_exclusive_or                  = 5'h0c,
    op_bitwise_invert                = 5'h0d,
    op_twos_complement_negate        = 5'h0e,
    op_set_bits_masked               = 5'h0f,
    op_clear_bits_masked             = 5'h10,
    op_plus_one                      = 5'h11,
    op_minus_one                     = 5'h12,
    op_zero_minus_test               = 5'h13,
    op_zero_register                 = 5'h14,
    op_set_all_ones                  = 5'h15,
    op_indirect_jump                 = 5'h16,
    op_indirect_call                 = 5'h17,
    op_compare_skip_equal            = 5'h18,
    op_compare_regs                  = 5'h19,
    op_compare_with_carry            = 5'h1a,
    op_compare_immediate             = 5'h1b,
    op_skip_if_bit_clear             = 5'h1c
  } op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_wait = 2'b10
  } state_t;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       h;
    logic       v;
  } alu_res_t;

  typedef struct packed {
    state_t      state;
    logic [1:0]  cnt;
    logic [7:0]  result;
    logic [7:0]  result_hi;
    logic [5:0]  p_flags;
    logic [5:0]  flags;
    logic [15:0] pc_next;
    logic [15:0] ret_addr;
    logic        p_wr;
    logic        p_wr_hi;
    logic        p_push;
    logic        wr;
    logic        wr_hi;
    logic        push;
    logic        busy;
    logic        done;
  } alu_state_t;
endpackage : cpu_alu_pkg

// *** design/cpu_alu_branch_subset.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cpu_alu_params.svh"
module cpu_alu_branch_subset (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire cpu_alu_pkg::op_t   op,
  input  wire logic [7:0]         dst_val,
  input  wire logic [7:0]         src_val,
  input  wire logic [7:0]         word_hi,
  input  wire logic [2:0]         bit_sel,
  input  wire logic [15:0]        z_ptr,
  input  wire logic [15:0]        pc_val,
  input  wire logic               next_two_words,
  output logic [7:0]              result,
  output logic [7:0]              result_hi,
  output logic                    result_wr,
  output logic                    result_hi_wr,
  output logic [5:0]              flags,
  output logic [15:0]             pc_next,
  output logic [15:0]             ret_addr,
  output logic                    ret_push,
  output logic                    busy,
  output logic                    done
);
  cpu_alu_pkg::alu_state_t s_q;
  cpu_alu_pkg::alu_state_t s_d;
  cpu_alu_pkg::alu_state_t s_rst;

  function automatic cpu_alu_pkg::alu_res_t add8(input logic [7:0] a,
      input logic [7:0] b, input logic ci);
    cpu_alu_pkg::alu_res_t o;
    logic [8:0] t;
    t     = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    o.res = t[7:0];
    o.c   = t[8];
    o.h   = (a[3] & b[3]) | (b[3] & ~t[3]) | (~t[3] & a[3]);
    o.v   = (a[7] & b[7] & ~t[7]) | (~a[7] & ~b[7] & t[7]);
    return o;
  endfunction : add8

  function automatic cpu_alu_pkg::alu_res_t sub8(input logic [7:0] a,
      input logic [7:0] b, input logic ci);
    cpu_alu_pkg::alu_res_t o;
    logic [8:0] t;
    t     = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    o.res = t[7:0];
    o.c   = t[8];
    o.h   = (~a[3] & b[3]) | (b[3] & t[3]) | (t[3] & ~a[3]);
    o.v   = (a[7] & ~b[7] & ~t[7]) | (~a[7] & b[7] & t[7]);
    return o;
  endfunction : sub8

  // Flag vector with the arithmetic flags replaced
  function automatic logic [5:0] arith_flags(input logic [5:0] f,
      input cpu_alu_pkg::alu_res_t r, input logic keep_z);
    logic [5:0] o;
    o = f;
    o[`ALU_FLAG_C] = r.c;
    o[`ALU_FLAG_H] = r.h;
    o[`ALU_FLAG_V] = r.v;
    o[`ALU_FLAG_N] = r.res[7];
    // Borrow chains only keep Z set when every byte was zero
    o[`ALU_FLAG_Z] = (r.res == 8'h00) & (keep_z ? f[`ALU_FLAG_Z] : 1'b1);
    return o;
  endfunction : arith_flags

  function automatic logic [5:0] logic_flags(input logic [5:0] f,
      input logic [7:0] r);
    logic [5:0] o;
    o = f;
    o[`ALU_FLAG_V] = 1'b0;
    o[`ALU_FLAG_N] = r[7];
    o[`ALU_FLAG_Z] = (r == 8'h00);
    return o;
  endfunction : logic_flags

  logic [15:0] word_in;
  logic [16:0] word_sum;
  logic [15:0] pc_seq;
  logic [15:0] pc_skip;
  logic [1:0]  skip_cyc;
  logic [1:0]  cyc;
  logic        fin;
  logic        cf;

  assign word_in  = {word_hi, dst_val};
  assign pc_seq   = pc_val + 16'h0001;
  // Skip length follows the next instruction's size [RULE16]
  assign pc_skip  = next_two_words ? pc_val + 16'h0003 : pc_val + 16'h0002;
  assign skip_cyc = next_two_words ? `ALU_CYC_THREE : `ALU_CYC_TWO;
  assign cf       = s_q.flags[`ALU_FLAG_C];

  always_comb begin
    s_rst         = '0;
    s_rst.state   = cpu_alu_pkg::st_idle;
    s_rst.flags   = `ALU_FLAGS_RESET;
    s_rst.p_flags = `ALU_FLAGS_RESET;
    s_d           = s_q;
    s_d.wr        = 1'b0;
    s_d.wr_hi     = 1'b0;
    s_d.push      = 1'b0;
    s_d.done      = 1'b0;
    cyc           = `ALU_CYC_ONE;
    fin           = 1'b0;
    word_sum      = '0;
    case (s_q.state)
      cpu_alu_pkg::st_idle: begin
        if (start) begin
          s_d.p_wr    = 1'b1;
          s_d.p_wr_hi = 1'b0;
          s_d.p_push  = 1'b0;
          s_d.p_flags = s_q.flags; // Unlisted flags hold [RULE17]
          s_d.pc_next = pc_seq;
          s_d.result  = dst_val;
          case (op)
            cpu_alu_pkg::op_add, cpu_alu_pkg::op_add_carry: begin
              s_d.result  = add8(dst_val, src_val,
                                 (op == cpu_alu_pkg::op_add_carry) & cf).res;
              s_d.p_flags = arith_flags(s_q.flags, add8(dst_val, src_val,
                  (op == cpu_alu_pkg::op_add_carry) & cf), 1'b0); // [RULE1]
            end
            cpu_alu_pkg::op_subtract, cpu_alu_pkg::op_subtract_constant,
            cpu_alu_pkg::op_twos_complement_negate: begin
              s_d.result  = (op == cpu_alu_pkg::op_twos_complement_negate) ?
                            sub8(8'h00, dst_val, 1'b0).res :
                            sub8(dst_val, src_val, 1'b0).res;
              s_d.p_flags = (op == cpu_alu_pkg::op_twos_complement_negate) ?
                arith_flags(s_q.flags, sub8(8'h00, dst_val, 1'b0), 1'b0) :
                arith_flags(s_q.flags, sub8(dst_val, src_val, 1'b0),
                            1'b0); // [RULE3]
            end
            cpu_alu_pkg::op_subtract_with_borrow,
            cpu_alu_pkg::op_subtract_constant_with_borrow: begin
              s_d.result  = sub8(dst_val, src_val, cf).res;
              s_d.p_flags = arith_flags(s_q.flags,
                  sub8(dst_val, src_val, cf), 1'b1); // [RULE4]
            end
            cpu_alu_pkg::op_compare_regs, cpu_alu_pkg::op_compare_immediate,
            cpu_alu_pkg::op_compare_with_carry: begin
              s_d.p_wr    = 1'b0; // Difference is discarded [RULE14]
              s_d.p_flags = (op == cpu_alu_pkg::op_compare_with_carry) ?
                arith_flags(s_q.flags, sub8(dst_val, src_val, cf), 1'b1) :
                arith_flags(s_q.flags, sub8(dst_val, src_val, 1'b0),
                            1'b0); // [RULE14]
            end
            cpu_alu_pkg::op_word_add_immediate,
            cpu_alu_pkg::op_word_subtract_immediate: begin
              word_sum = (op == cpu_alu_pkg::op_word_add_immediate) ?
                {1'b0, word_in} + {9'h000, src_val} :
                {1'b0, word_in} - {9'h000, src_val}; // [RULE2] [RULE5]
              cyc             = `ALU_CYC_TWO;
              s_d.p_wr_hi     = 1'b1;
              s_d.result      = word_sum[7:0];
              s_d.result_hi   = word_sum[15:8];
              s_d.p_flags[`ALU_FLAG_C] = word_sum[16];
              s_d.p_flags[`ALU_FLAG_N] = word_sum[15];
              s_d.p_flags[`ALU_FLAG_Z] = (word_sum[15:0] == 16'h0000);
              s_d.p_flags[`ALU_FLAG_V] =
                (op == cpu_alu_pkg::op_word_add_immediate) ?
                (~word_hi[7] & word_sum[15]) : (word_hi[7] & ~word_sum[15]);
              s_d.p_flags[`ALU_FLAG_S] = word_sum[15] ^
                s_d.p_flags[`ALU_FLAG_V]; // [RULE2] [RULE5]
            end
            cpu_alu_pkg::op_and, cpu_alu_pkg::op_and_constant,
            cpu_alu_pkg::op_zero_minus_test: begin
              s_d.result  = (op == cpu_alu_pkg::op_zero_minus_test) ?
                            (dst_val & dst_val) : (dst_val & src_val);
              s_d.p_flags = logic_flags(s_q.flags,
                s_d.result); // [RULE6] [RULE10]
            end
            cpu_alu_pkg::op_or, cpu_alu_pkg::op_or_constant,
            cpu_alu_pkg::op_set_bits_masked, cpu_alu_pkg::op_exclusive_or,
            cpu_alu_pkg::op_zero_register: begin
              s_d.result  = (op == cpu_alu_pkg::op_exclusive_or) ?
                            (dst_val ^ src_val) :
                            (op == cpu_alu_pkg::op_zero_register) ? 8'h00 :
                            (dst_val | src_val);
              s_d.p_flags = logic_flags(s_q.flags, s_d.result); // [RULE7]
            end
            cpu_alu_pkg::op_clear_bits_masked: begin
              s_d.result  = dst_val & (`ALU_ALL_ONES - src_val);
              s_d.p_flags = logic_flags(s_q.flags, s_d.result); // [RULE9]
            end
            cpu_alu_pkg::op_bitwise_invert: begin
              s_d.result  = `ALU_ALL_ONES - dst_val;
              s_d.p_flags = logic_flags(s_q.flags, s_d.result);
              s_d.p_flags[`ALU_FLAG_C] = 1'b1; // [RULE8]
            end
            cpu_alu_pkg::op_plus_one, cpu_alu_pkg::op_minus_one: begin
              s_d.result  = (op == cpu_alu_pkg::op_plus_one) ?
                            dst_val + 8'h01 : dst_val - 8'h01;
              s_d.p_flags = logic_flags(s_q.flags, s_d.result);
              s_d.p_flags[`ALU_FLAG_V] = (op == cpu_alu_pkg::op_plus_one) ?
                (s_d.result == 8'h80) : (s_d.result == 8'h7f);
            end
            cpu_alu_pkg::op_set_all_ones: s_d.result = `ALU_ALL_ONES;
            cpu_alu_pkg::op_indirect_jump: begin
              s_d.p_wr    = 1'b0;
              s_d.pc_next = z_ptr; // [RULE11]
              cyc         = `ALU_CYC_TWO;
            end
            cpu_alu_pkg::op_indirect_call: begin
              s_d.p_wr     = 1'b0;
              s_d.p_push   = 1'b1;
              s_d.ret_addr = pc_seq;
              s_d.pc_next  = z_ptr; // [RULE12]
              cyc          = `ALU_CYC_THREE;
            end
            cpu_alu_pkg::op_compare_skip_equal: begin
              s_d.p_wr = 1'b0;
              if (dst_val == src_val) begin
                s_d.pc_next = pc_skip; // [RULE13]
                cyc         = skip_cyc;
              end
            end
            cpu_alu_pkg::op_skip_if_bit_clear: begin
              s_d.p_wr = 1'b0;
              if (!dst_val[bit_sel]) begin
                s_d.pc_next = pc_skip; // [RULE15]
                cyc         = skip_cyc;
              end
            end
            default: s_d.p_wr = 1'b0;
          endcase
          if (cyc == `ALU_CYC_ONE) begin
            fin = 1'b1;
          end else begin
            s_d.state = cpu_alu_pkg::st_wait;
            s_d.cnt   = cyc - 2'h1;
            s_d.busy  = 1'b1;
          end
        end
      end
      cpu_alu_pkg::st_wait: begin
        if (s_q.cnt == 2'h1) begin
          fin = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 2'h1;
        end
      end
      default: s_d = s_rst;
    endcase
    // Write strobes, push and flags are published together at the end; result, pc_next and ret_addr already load at start
    if (fin) begin
      s_d.state = cpu_alu_pkg::st_idle;
      s_d.busy  = 1'b0;
      s_d.cnt   = 2'h0;
      s_d.done  = 1'b1;
      s_d.wr    = s_d.p_wr;
      s_d.wr_hi = s_d.p_wr_hi;
      s_d.push  = s_d.p_push;
      s_d.flags = s_d.p_flags;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= s_rst;
    end else begin
      s_q <= s_d;
    end
  end

  assign result       = s_q.result;
  assign result_hi    = s_q.result_hi;
  assign result_wr    = s_q.wr;
  assign result_hi_wr = s_q.wr_hi;
  assign flags        = s_q.flags;
  assign pc_next      = s_q.pc_next;
  assign ret_addr     = s_q.ret_addr;
  assign ret_push     = s_q.push;
  assign busy         = s_q.busy;
  assign done         = s_q.done;

  logic take1;
  assign take1 = start & ~s_q.busy;

  one_cycle_a: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
    take1 && op == cpu_alu_pkg::op_add |=> done && result_wr &&
    result == $past(dst_val + src_val))
    else $error("add result or timing wrong");
  word_two_a: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
    take1 && op == cpu_alu_pkg::op_word_add_immediate |=> busy && !done
    ##1 done && result_hi_wr && {result_hi, result} ==
    $past({word_hi, dst_val}, 2) + {8'h00, $past(src_val, 2)})
    else $error("word add wrong");
  sub_borrow_a: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
    take1 && op == cpu_alu_pkg::op_subtract_with_borrow |=>
    result == $past(dst_val - src_val - {7'h00, flags[`ALU_FLAG_C]}))
    else $error("borrow subtract wrong");
  logic_flags_a: assert property (@(posedge mclk) disable iff (rst) // [RULE6]
    take1 && op == cpu_alu_pkg::op_and |=> !flags[`ALU_FLAG_V] &&
    flags[`ALU_FLAG_C] == $past(flags[`ALU_FLAG_C]) &&
    flags[`ALU_FLAG_H] == $past(flags[`ALU_FLAG_H]))
    else $error("logic op touched other flags");
  invert_val_a: assert property (@(posedge mclk) disable iff (rst) // [RULE8]
    take1 && op == cpu_alu_pkg::op_bitwise_invert |=>
    result == ~$past(dst_val) && flags[`ALU_FLAG_C])
    else $error("invert wrong");
  jump_two_a: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
    take1 && op == cpu_alu_pkg::op_indirect_jump |=> !done ##1 done &&
    pc_next == $past(z_ptr, 2) && flags == $past(flags, 2))
    else $error("indirect jump wrong");
  call_three_a: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
    take1 && op == cpu_alu_pkg::op_indirect_call |=> !done [*2] ##1
    done && ret_push && ret_addr == $past(pc_val, 3) + 16'h0001)
    else $error("indirect call wrong");
  skip_len_a: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
    take1 && op == cpu_alu_pkg::op_skip_if_bit_clear && !dst_val[bit_sel] &&
    next_two_words |=> !done [*2] ##1 done &&
    pc_next == $past(pc_val, 3) + 16'h0003)
    else $error("skip length wrong");
  cmp_nowrite_a: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
    take1 && op == cpu_alu_pkg::op_compare_immediate |=> done && !result_wr &&
    flags[`ALU_FLAG_Z] == ($past(dst_val) == $past(src_val)))
    else $error("compare wrong");
  busy_done_c: cover property (@(posedge mclk) disable iff (rst)
    busy ##[1:2] done);
  skip_equal_c: cover property (@(posedge mclk) disable iff (rst)
    take1 && op == cpu_alu_pkg::op_compare_skip_equal && dst_val == src_val);
  call_push_c: cover property (@(posedge mclk) disable iff (rst) ret_push);
endmodule : cpu_alu_branch_subset
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic             mclk           = 1'b0;
  logic             rst            = 1'b1;
  logic             start          = 1'b0;
  cpu_alu_pkg::op_t op             = cpu_alu_pkg::op_add;
  logic [7:0]       dst_val        = 8'h00;
  logic [7:0]       src_val        = 8'h00;
  logic [7:0]       word_hi        = 8'h00;
  logic [2:0]       bit_sel        = 3'h0;
  logic [15:0]      z_ptr          = 16'h0abc;
  logic [15:0]      pc_val         = 16'h1234;
  logic             next_two_words = 1'b0;
  logic [7:0]       result;
  logic [7:0]       result_hi;
  logic             result_wr;
  logic             result_hi_wr;
  logic [5:0]       flags;
  logic [15:0]      pc_next;
  logic [15:0]      ret_addr;
  logic             ret_push;
  logic             busy;
  logic             done;
  logic [5:0]       f_exp          = 6'h00;
  int               n_fail         = 0;
  int               checked        = 0;
  int               cyc;
  int               k;

  always #5 mclk = ~mclk;

  cpu_alu_branch_subset dut_u (
    .mclk(mclk), .rst(rst), .start(start), .op(op), .dst_val(dst_val),
    .src_val(src_val), .word_hi(word_hi), .bit_sel(bit_sel),
    .z_ptr(z_ptr), .pc_val(pc_val), .next_two_words(next_two_words),
    .result(result), .result_hi(result_hi), .result_wr(result_wr),
    .result_hi_wr(result_hi_wr), .flags(flags), .pc_next(pc_next),
    .ret_addr(ret_addr), .ret_push(ret_push), .busy(busy), .done(done)
  );

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Leaves the bench one step past the done edge, so pulses are visible
  task automatic run(input cpu_alu_pkg::op_t o, input logic [7:0] d, s);
    @(posedge mclk);
    #1;
    start = 1'b1;
    op = o;
    dst_val = d;
    src_val = s;
    @(posedge mclk);
    #1;
    start = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      @(posedge mclk);
      #1;
      cyc++;
    end
  endtask : run

  task automatic byte_op(input cpu_alu_pkg::op_t o, input logic [7:0] d, s);
    logic [8:0] w;
    logic [7:0] r;
    logic       sub;
    logic       arith;
    w = 9'h000;
    sub = 1'b0;
    arith = 1'b1;
    case (o)
      cpu_alu_pkg::op_add:       w = d + s;
      cpu_alu_pkg::op_add_carry: w = d + s + f_exp[0];
      cpu_alu_pkg::op_subtract, cpu_alu_pkg::op_subtract_constant,
      cpu_alu_pkg::op_compare_immediate, cpu_alu_pkg::op_compare_regs: begin
        w = d - s;
        sub = 1'b1;
      end
      cpu_alu_pkg::op_subtract_with_borrow,
      cpu_alu_pkg::op_compare_with_carry,
      cpu_alu_pkg::op_subtract_constant_with_borrow: begin
        w = d - s - f_exp[0];
        sub = 1'b1;
      end
      default: arith = 1'b0;
    endcase
    case (o)
      cpu_alu_pkg::op_and, cpu_alu_pkg::op_and_constant: r = d & s;
      cpu_alu_pkg::op_or, cpu_alu_pkg::op_or_constant:   r = d | s;
      cpu_alu_pkg::op_exclusive_or:      r = d ^ s;
      cpu_alu_pkg::op_bitwise_invert:    r = 8'hff - d;
      cpu_alu_pkg::op_clear_bits_masked: r = d & (8'hff - s);
      cpu_alu_pkg::op_zero_minus_test:   r = d & d;
      default:                           r = w[7:0];
    endcase
    if (arith) begin
      f_exp[0] = w[8];
      f_exp[5] = sub ? (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3])
                     : (d[3] & s[3]) | (s[3] & ~r[3]) | (~r[3] & d[3]);
      f_exp[3] = sub ? (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7])
                     : (d[7] & s[7] & ~r[7]) | (~d[7] & ~s[7] & r[7]);
    end else begin
      f_exp[3] = 1'b0;
    end
    if (o == cpu_alu_pkg::op_bitwise_invert) f_exp[0] = 1'b1;
    // Borrow forms only clear Z, so multi-byte compares chain
    if (o == cpu_alu_pkg::op_subtract_with_borrow ||
        o == cpu_alu_pkg::op_compare_with_carry ||
        o == cpu_alu_pkg::op_subtract_constant_with_borrow) begin
      f_exp[1] = (r == 8'h00) & f_exp[1];
    end else begin
      f_exp[1] = (r == 8'h00);
    end
    f_exp[2] = r[7];
    run(o, d, s);
    chk("cycles", cyc, 16'h0001);
    chk("flags", flags, f_exp);
    if (o == cpu_alu_pkg::op_compare_immediate ||
        o == cpu_alu_pkg::op_compare_regs ||
        o == cpu_alu_pkg::op_compare_with_carry) begin
      chk("result_wr", result_wr, 16'h0000);
    end else begin
      chk("result", result, r);
      chk("result_wr", result_wr, 16'h0001);
    end
  endtask : byte_op

  task automatic word_op(input logic sub, input logic [7:0] hi, lo, kk);
    logic [15:0] w;
    w = sub ? {hi, lo} - kk : {hi, lo} + kk;
    f_exp[0] = sub ? w[15] & ~hi[7] : ~w[15] & hi[7];
    f_exp[3] = sub ? hi[7] & ~w[15] : ~hi[7] & w[15];
    f_exp[1] = (w == 16'h0000);
    f_exp[2] = w[15];
    f_exp[4] = f_exp[2] ^ f_exp[3];
    word_hi = hi;
    run(sub ? cpu_alu_pkg::op_word_subtract_immediate
            : cpu_alu_pkg::op_word_add_immediate, lo, kk);
    chk("word cycles", cyc, 16'h0002);
    chk("word", {result_hi, result}, w);
    chk("result_hi_wr", result_hi_wr, 16'h0001);
    chk("word flags", flags, f_exp);
  endtask : word_op

  task automatic flow(input cpu_alu_pkg::op_t o, input logic [7:0] d, s,
                      input logic [2:0] b, input logic two,
                      input logic [15:0] pc_e, input int n_e);
    bit_sel = b;
    next_two_words = two;
    run(o, d, s);
    chk("flow cycles", cyc, n_e[15:0]);
    chk("pc_next", pc_next, pc_e);
    chk("flow flags", flags, f_exp);
  endtask : flow

  initial begin
    #50000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("reset flags", flags, 16'h0000);
    chk("reset busy", {busy, done}, 16'h0000);
    byte_op(cpu_alu_pkg::op_add, 8'h0f, 8'h01);
    byte_op(cpu_alu_pkg::op_add, 8'h80, 8'h80);
    byte_op(cpu_alu_pkg::op_add_carry, 8'h7f, 8'h00);
    byte_op(cpu_alu_pkg::op_subtract, 8'h00, 8'h01);
    byte_op(cpu_alu_pkg::op_subtract_constant, 8'h80, 8'h01);
    byte_op(cpu_alu_pkg::op_subtract, 8'h00, 8'h01);
    byte_op(cpu_alu_pkg::op_subtract_constant_with_borrow,
            8'h02, 8'h01);
    byte_op(cpu_alu_pkg::op_subtract, 8'h10, 8'h10);
    byte_op(cpu_alu_pkg::op_subtract_with_borrow, 8'h01, 8'h01);
    byte_op(cpu_alu_pkg::op_add, 8'h88, 8'h88);
    byte_op(cpu_alu_pkg::op_and, 8'hf0, 8'h0f);
    byte_op(cpu_alu_pkg::op_and_constant, 8'hc3, 8'h81);
    byte_op(cpu_alu_pkg::op_or, 8'h00, 8'h00);
    byte_op(cpu_alu_pkg::op_or_constant, 8'h40, 8'h82);
    byte_op(cpu_alu_pkg::op_exclusive_or, 8'haa, 8'h55);
    byte_op(cpu_alu_pkg::op_clear_bits_masked, 8'hff, 8'h0f);
    byte_op(cpu_alu_pkg::op_zero_minus_test, 8'h00, 8'h00);
    byte_op(cpu_alu_pkg::op_zero_minus_test, 8'h80, 8'h00);
    byte_op(cpu_alu_pkg::op_bitwise_invert, 8'hff, 8'h00);
    byte_op(cpu_alu_pkg::op_bitwise_invert, 8'h5a, 8'h00);
    byte_op(cpu_alu_pkg::op_compare_immediate, 8'h10, 8'h20);
    byte_op(cpu_alu_pkg::op_compare_immediate, 8'h33, 8'h33);
    byte_op(cpu_alu_pkg::op_compare_regs, 8'h01, 8'h02);
    byte_op(cpu_alu_pkg::op_compare_with_carry, 8'h00, 8'h00);
    word_op(1'b0, 8'h00, 8'hff, 8'h01);
    word_op(1'b0, 8'hff, 8'hff, 8'h01);
    word_op(1'b0, 8'h7f, 8'hff, 8'h01);
    word_op(1'b1, 8'h00, 8'h00, 8'h01);
    word_op(1'b1, 8'h80, 8'h00, 8'h3f);
    flow(cpu_alu_pkg::op_indirect_jump, 8'h00, 8'h00, 3'h0, 1'b0,
         z_ptr, 2);
    flow(cpu_alu_pkg::op_indirect_call, 8'h00, 8'h00, 3'h0, 1'b0,
         z_ptr, 3);
    chk("ret_addr", ret_addr, pc_val + 16'h0001);
    chk("ret_push", ret_push, 16'h0001);
    // Equal and unequal, each before a one- and a two-word instruction
    for (int i = 0; i < 4; i++) begin
      k = i[0] ? 2 + i[1] : 1;
      flow(cpu_alu_pkg::op_compare_skip_equal, 8'h5a, i[0] ? 8'h5a : 8'h5b,
           3'h0, i[1], pc_val + k[15:0], k);
    end
    for (int i = 0; i < 16; i++) begin
      k = i[3] ? 1 : 2 + i[0];
      flow(cpu_alu_pkg::op_skip_if_bit_clear,
           i[3] ? 8'h01 << i[2:0] : ~(8'h01 << i[2:0]), 8'h00,
           i[2:0], i[0], pc_val + k[15:0], k);
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
